// ===== logic/amc_cfg.svh
// offsets, field positions, reset values and timing counts of the motion-event block
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH
// register indices; byte address is four times the index
`define AMC_IDX_FF_DLY 6'h22
`define AMC_IDX_FF_LVL 6'h23
`define AMC_IDX_HYS 6'h24
`define AMC_IDX_SH_DLY 6'h25
`define AMC_IDX_SH_LVL 6'h26
`define AMC_IDX_DUR 6'h27
`define AMC_IDX_AM_LVL 6'h28
`define AMC_IDX_QM_LVL 6'h29
`define AMC_IDX_CTRL 6'h30
`define AMC_IDX_STAT 6'h31
`define AMC_IDX_MASK 6'h32
// reset values
`define AMC_RST_FF_DLY 8'h09
`define AMC_RST_FF_LVL 8'h30
`define AMC_RST_HYS 8'h81
`define AMC_RST_SH_DLY 8'h0F
`define AMC_RST_SH_LVL 8'hC0
`define AMC_RST_DUR 8'h00
`define AMC_RST_AM_LVL 8'h14
`define AMC_RST_QM_LVL 8'h14
`define AMC_RST_CTRL 8'h00
`define AMC_RST_MASK 8'h00
// field positions
`define AMC_SH_HY_LSB 6
`define AMC_FF_MODE_BIT 2
`define AMC_QM_DUR_LSB 2
`define AMC_CTRL_QSEL_BIT 0
`define AMC_EV_FF 0
`define AMC_EV_SH 1
`define AMC_EV_AM 2
`define AMC_EV_QM 3
// step shifts, sample lsb = 3.90625 mg; range shifts add meas_range
`define AMC_FF_LVL_SHIFT 1
`define AMC_FF_HY_SHIFT 5
`define AMC_SH_LVL_SHIFT 1
`define AMC_SH_HY_SHIFT 5
// timing
`define AMC_CLK_HZ 10000000
`define AMC_TICK_MS 2
`define AMC_TICK_CYC ((`AMC_CLK_HZ / 1000) * `AMC_TICK_MS)
`define AMC_TICKS_PER_S (1000 / `AMC_TICK_MS)
`endif

// ===== logic/amc_pkg.sv
// types shared by the motion-event block
package amc_pkg;
   typedef enum logic [1:0] {
      AMC_R2G = 2'b00,
      AMC_R4G = 2'b01,
      AMC_R8G = 2'b10,
      AMC_R16G = 2'b11
   } amc_range_e;
   typedef struct packed {
      logic valid;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } amc_sample_s;
   typedef logic [17:0] amc_mag_t;
endpackage

// ===== logic/amc_top.sv
// motion-event detectors with their configuration registers behind an axi4-lite slave
// Behaviour
// - free-fall level is field times 7.81 mg, any range.
// - free-fall mode 0 checks each axis; mode 1 checks axis sum.
// - free-fall hysteresis is field times 125 mg, any range.
// - shock hysteresis step 125/250/500/1000 mg per range.
// - shock must persist (delay field plus one) times 2 ms.
// - shock level step 7.81/15.63/31.25/62.5 mg per range.
// - any-motion fires after (count field plus one) consecutive slopes above level.
// - slope compared with any-motion field times 3.91..31.25 mg per range.
// - slow-motion fires after (duration bits 3:2 plus one) slopes above level.
// - no-motion fires when no slope exceeds level for the duration time.
// - no-motion seconds decoded in three piecewise linear segments.
// - free-fall level resets to 375 mg.
// - shock delay resets to 32 ms.
// - free-fall must persist (delay field plus one) times 2 ms.
// - quiet-motion level is field times range step, as sample difference.
`timescale 1ns/10ps
`include "amc_cfg.svh"

// counts ticks while a condition holds and pulses once when the limit is met
module amc_persist #(
   parameter int W = 9
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic cond,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   // event
   output logic fire
);
   logic [W-1:0] cnt_q;
   logic done_q;
   assign fire = cond && !done_q && (cnt_q == limit);
   always_ff @(posedge aclk) begin
      if (!aresetn || !cond) begin
         cnt_q <= '0;
      end else if (tick && !done_q && cnt_q != limit) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !cond) begin
         done_q <= 1'b0;
      end else if (fire) begin
         done_q <= 1'b1;
      end
   end
   property p_persist_once;
      @(posedge aclk) disable iff (!aresetn) fire |=> !fire;
   endproperty
   a_persist_once: assert property (p_persist_once) else $error("persist fired twice");
   property p_persist_cond;
      @(posedge aclk) disable iff (!aresetn) !cond |-> !fire;
   endproperty
   a_persist_cond: assert property (p_persist_cond) else $error("fire without cond");
endmodule

// counts consecutive qualifying samples and pulses when the run reaches the limit
module amc_run (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // sample qualification
   input wire logic step,
   input wire logic above,
   input wire logic [2:0] limit,
   // event
   output logic fire
);
   logic [2:0] run_q;
   assign fire = step && above && (run_q + 3'd1 == limit);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 3'h0;
      end else if (step) begin
         // saturate so a long run fires only once
         run_q <= !above ? 3'h0 : (run_q == 3'h4) ? run_q : run_q + 3'd1;
      end
   end
   sequence s_break;
      step && !above;
   endsequence
   property p_run_clear;
      @(posedge aclk) disable iff (!aresetn) s_break |=> run_q == 3'h0;
   endproperty
   a_run_clear: assert property (p_run_clear) else $error("run not cleared");
   property p_run_fire;
      @(posedge aclk) disable iff (!aresetn) fire |-> run_q == limit - 3'd1 && above;
   endproperty
   a_run_fire: assert property (p_run_fire) else $error("run fired early");
endmodule

module amc_top #(
   parameter int TICK_CYCLES = `AMC_TICK_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // sample stream and live range
   input wire amc_pkg::amc_sample_s smp,
   input wire amc_pkg::amc_range_e meas_range,
   // interrupt
   output logic irq
);
   import amc_pkg::*;

   logic [7:0] ff_dly_q, ff_lvl_q, hys_q, sh_dly_q, sh_lvl_q, dur_q, am_lvl_q, qm_lvl_q;
   logic [7:0] ctrl_q, mask_q;
   logic [3:0] stat_q, ev;
   logic aw_hold_q, w_hold_q, wr_go, wr_en;
   logic [5:0] aw_idx_q;
   logic [7:0] w_byte_q;
   logic w_lane_q;
   logic ff_cond_q, sh_cond_q, quiet_q, prev_ok_q;
   logic [15:0] px_q, py_q, pz_q;
   logic [15:0] tick_cnt_q;
   logic tick;

   function automatic logic is_mapped(input logic [5:0] i);
      return (i >= `AMC_IDX_FF_DLY && i <= `AMC_IDX_QM_LVL) ||
             (i >= `AMC_IDX_CTRL && i <= `AMC_IDX_MASK);
   endfunction

   function automatic amc_mag_t abs18(input amc_mag_t v);
      return v[17] ? amc_mag_t'(-v) : v;
   endfunction

   function automatic amc_mag_t sx(input logic [15:0] v);
      return {{2{v[15]}}, v};
   endfunction

   // ---------------- axi4-lite write channel ----------------
   assign awready = !aw_hold_q && !bvalid;
   assign wready = !w_hold_q && !bvalid;
   assign wr_go = aw_hold_q && w_hold_q;
   assign wr_en = wr_go && w_lane_q && is_mapped(aw_idx_q);

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_go) begin
         aw_hold_q <= 1'b0;
      end else if (awvalid && awready) begin
         aw_hold_q <= 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_idx_q <= 6'h00;
      end else if (awvalid && awready) begin
         aw_idx_q <= awaddr[7:2];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || wr_go) begin
         w_hold_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_hold_q <= 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_byte_q <= 8'h00;
         w_lane_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_byte_q <= wdata[7:0];
         w_lane_q <= wstrb[0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= 2'h0;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp <= is_mapped(aw_idx_q) ? 2'h0 : 2'h2;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // configuration registers; lane 0 only carries data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ff_dly_q <= `AMC_RST_FF_DLY;
         ff_lvl_q <= `AMC_RST_FF_LVL;
         hys_q <= `AMC_RST_HYS;
         sh_dly_q <= `AMC_RST_SH_DLY;
         sh_lvl_q <= `AMC_RST_SH_LVL;
         dur_q <= `AMC_RST_DUR;
         am_lvl_q <= `AMC_RST_AM_LVL;
         qm_lvl_q <= `AMC_RST_QM_LVL;
         ctrl_q <= `AMC_RST_CTRL;
         mask_q <= `AMC_RST_MASK;
      end else if (wr_en) begin
         case (aw_idx_q)
            `AMC_IDX_FF_DLY: ff_dly_q <= w_byte_q;
            `AMC_IDX_FF_LVL: ff_lvl_q <= w_byte_q;
            `AMC_IDX_HYS: hys_q <= w_byte_q & 8'hC7;
            `AMC_IDX_SH_DLY: sh_dly_q <= w_byte_q;
            `AMC_IDX_SH_LVL: sh_lvl_q <= w_byte_q;
            `AMC_IDX_DUR: dur_q <= w_byte_q;
            `AMC_IDX_AM_LVL: am_lvl_q <= w_byte_q;
            `AMC_IDX_QM_LVL: qm_lvl_q <= w_byte_q;
            `AMC_IDX_CTRL: ctrl_q <= w_byte_q & 8'h01;
            `AMC_IDX_MASK: mask_q <= w_byte_q & 8'h0F;
            default: ;
         endcase
      end
   end

   // ---------------- axi4-lite read channel ----------------
   function automatic logic [7:0] rd_byte(input logic [5:0] i);
      case (i)
         // the two free-fall delay/level bytes keep a write-only top bit
         `AMC_IDX_FF_DLY: rd_byte = {1'b0, ff_dly_q[6:0]};
         `AMC_IDX_FF_LVL: rd_byte = {1'b0, ff_lvl_q[6:0]};
         `AMC_IDX_HYS: rd_byte = hys_q;
         `AMC_IDX_SH_DLY: rd_byte = sh_dly_q;
         `AMC_IDX_SH_LVL: rd_byte = sh_lvl_q;
         `AMC_IDX_DUR: rd_byte = dur_q;
         `AMC_IDX_AM_LVL: rd_byte = am_lvl_q;
         `AMC_IDX_QM_LVL: rd_byte = qm_lvl_q;
         `AMC_IDX_CTRL: rd_byte = ctrl_q;
         `AMC_IDX_STAT: rd_byte = {2'b00, sh_cond_q, ff_cond_q, stat_q};
         `AMC_IDX_MASK: rd_byte = mask_q;
         default: rd_byte = 8'h00;
      endcase
   endfunction

   assign arready = !rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= 2'h0;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= {24'h0, rd_byte(araddr[7:2])};
         rresp <= is_mapped(araddr[7:2]) ? 2'h0 : 2'h2;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------- sample front end ----------------
   amc_mag_t ax, ay, az, amax, asum, smax, dx, dy, dz;
   amc_mag_t ff_th, ff_hy, sh_th, sh_hy, sh_lo, am_th, qm_th;
   logic ff_in, ff_out, step;

   assign ax = abs18(sx(smp.x));
   assign ay = abs18(sx(smp.y));
   assign az = abs18(sx(smp.z));
   assign asum = ax + ay + az;
   assign amax = (ax > ay) ? ((ax > az) ? ax : az) : ((ay > az) ? ay : az);
   assign dx = abs18(sx(smp.x) - sx(px_q));
   assign dy = abs18(sx(smp.y) - sx(py_q));
   assign dz = abs18(sx(smp.z) - sx(pz_q));
   assign smax = (dx > dy) ? ((dx > dz) ? dx : dz) : ((dy > dz) ? dy : dz);
   assign step = smp.valid && prev_ok_q;

   // sample lsb is 1/256 g, so every step is a power-of-two shift
   assign ff_th = {10'h0, ff_lvl_q} << `AMC_FF_LVL_SHIFT;
   assign ff_hy = {16'h0, hys_q[1:0]} << `AMC_FF_HY_SHIFT;
   assign sh_th = {10'h0, sh_lvl_q} << (`AMC_SH_LVL_SHIFT + meas_range);
   assign sh_hy = {16'h0, hys_q[`AMC_SH_HY_LSB+:2]} << (`AMC_SH_HY_SHIFT + meas_range);
   assign sh_lo = (sh_th > sh_hy) ? sh_th - sh_hy : '0;
   assign am_th = {10'h0, am_lvl_q} << meas_range;
   assign qm_th = {10'h0, qm_lvl_q} << meas_range;

   // summing mode looks at the axis sum, single mode needs every axis low
   assign ff_in = hys_q[`AMC_FF_MODE_BIT] ? (asum < ff_th) :
                  (ax < ff_th && ay < ff_th && az < ff_th);
   assign ff_out = hys_q[`AMC_FF_MODE_BIT] ? (asum > ff_th + ff_hy) :
                   (amax > ff_th + ff_hy);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ff_cond_q <= 1'b0;
         sh_cond_q <= 1'b0;
      end else if (smp.valid) begin
         ff_cond_q <= ff_cond_q ? !ff_out : ff_in;
         sh_cond_q <= sh_cond_q ? (amax > sh_lo) : (amax > sh_th);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         quiet_q <= 1'b0;
      end else if (step) begin
         quiet_q <= !(smax > qm_th);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         px_q <= 16'h0;
         py_q <= 16'h0;
         pz_q <= 16'h0;
         prev_ok_q <= 1'b0;
      end else if (smp.valid) begin
         px_q <= smp.x;
         py_q <= smp.y;
         pz_q <= smp.z;
         prev_ok_q <= 1'b1;
      end
   end

   // 2 ms time base shared by the persistence timers
   assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_q <= 16'h0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h1;
      end
   end

   // ---------------- detectors ----------------
   logic [8:0] nm_secs;
   logic [17:0] nm_lim;
   logic nm_fire, sm_fire, qsel;

   always_comb begin
      case (dur_q[7:6])
         2'b00: nm_secs = {5'h0, dur_q[5:2]} + 9'd1;
         2'b01: nm_secs = {3'h0, dur_q[5:2], 2'b00} + 9'd20;
         default: nm_secs = {1'b0, dur_q[6:2], 3'b000} + 9'd88;
      endcase
   end
   assign nm_lim = 18'(nm_secs * `AMC_TICKS_PER_S);
   assign qsel = ctrl_q[`AMC_CTRL_QSEL_BIT];

   amc_persist #(.W(9)) u_ff (
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(ff_cond_q),
      .tick(tick),
      .limit({1'b0, ff_dly_q} + 9'd1),
      .fire(ev[`AMC_EV_FF])
   );
   amc_persist #(.W(9)) u_sh (
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(sh_cond_q),
      .tick(tick),
      .limit({1'b0, sh_dly_q} + 9'd1),
      .fire(ev[`AMC_EV_SH])
   );
   amc_run u_am (
      .aclk(aclk),
      .aresetn(aresetn),
      .step(step),
      .above(smax > am_th),
      .limit({1'b0, dur_q[1:0]} + 3'd1),
      .fire(ev[`AMC_EV_AM])
   );
   amc_run u_sm (
      .aclk(aclk),
      .aresetn(aresetn),
      .step(step && !qsel),
      .above(smax > qm_th),
      .limit({1'b0, dur_q[`AMC_QM_DUR_LSB+:2]} + 3'd1),
      .fire(sm_fire)
   );
   amc_persist #(.W(18)) u_nm (
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(quiet_q && qsel),
      .tick(tick),
      .limit(nm_lim),
      .fire(nm_fire)
   );
   assign ev[`AMC_EV_QM] = qsel ? nm_fire : sm_fire;

   // ---------------- interrupt status ----------------
   logic [3:0] clr;
   assign clr = (wr_en && aw_idx_q == `AMC_IDX_STAT) ? w_byte_q[3:0] : 4'h0;
   // a new event in the clearing cycle survives the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= (stat_q & ~clr) | ev;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q[3:0]);
      end
   end

   // ---------------- checks ----------------
   property p_ff_reset;
      @(posedge aclk) !aresetn |=> ff_lvl_q == `AMC_RST_FF_LVL;
   endproperty
   a_ff_reset: assert property (p_ff_reset) else $error("free-fall level reset");
   property p_sh_reset;
      @(posedge aclk) !aresetn |=> sh_dly_q == `AMC_RST_SH_DLY;
   endproperty
   a_sh_reset: assert property (p_sh_reset) else $error("shock delay reset");
   property p_ff_single;
      @(posedge aclk) disable iff (!aresetn)
         smp.valid && !ff_cond_q && !hys_q[`AMC_FF_MODE_BIT] && amax >= ff_th |=> !ff_cond_q;
   endproperty
   a_ff_single: assert property (p_ff_single) else $error("free-fall axis test");
   property p_sh_enter;
      @(posedge aclk) disable iff (!aresetn) smp.valid && amax > sh_th |=> sh_cond_q;
   endproperty
   a_sh_enter: assert property (p_sh_enter) else $error("shock level missed");
   property p_ev_sticky;
      @(posedge aclk) disable iff (!aresetn) ev[`AMC_EV_SH] |=> stat_q[`AMC_EV_SH];
   endproperty
   a_ev_sticky: assert property (p_ev_sticky) else $error("shock flag lost");
   property p_nm_quiet;
      @(posedge aclk) disable iff (!aresetn) ev[`AMC_EV_QM] && qsel |-> quiet_q;
   endproperty
   a_nm_quiet: assert property (p_nm_quiet) else $error("no-motion while moving");
   // duration code 1 means 2 s, which is 1000 ticks of 2 ms
   property p_nm_decode;
      @(posedge aclk) disable iff (!aresetn)
         qsel && dur_q[7:2] == 6'h01 |-> nm_lim == 18'd1000;
   endproperty
   a_nm_decode: assert property (p_nm_decode) else $error("no-motion decode");
   sequence s_status_set;
      (stat_q & mask_q[3:0]) != 4'h0;
   endsequence
   property p_irq;
      @(posedge aclk) disable iff (!aresetn) s_status_set ##1 s_status_set |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");
   sequence s_wr_pair;
      aw_hold_q && w_hold_q;
   endsequence
   property p_bresp;
      @(posedge aclk) disable iff (!aresetn) s_wr_pair |=> bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");
   property p_bhold;
      @(posedge aclk) disable iff (!aresetn) bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule

// ===== tb/test_accel_motion_event_config.sv
// self-checking bench for the motion-event register block over axi4-lite
`timescale 1ns/10ps
module test_accel_motion_event_config;
   import amc_pkg::*;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr;
   logic [7:0] araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   amc_sample_s smp;
   amc_range_e meas_range;
   int mismatches;
   int check_count;
   logic [31:0] rd;
   logic [1:0] rs;
   logic [5:0] ridx [11] = '{6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29,
      6'h30, 6'h31, 6'h32};
   logic [7:0] rval [11] = '{8'h09, 8'h30, 8'h81, 8'h0F, 8'hC0, 8'h00, 8'h14, 8'h14,
      8'h00, 8'h00, 8'h00};

   // one "2 ms" tick is 10 cycles, so one second is 5000 cycles
   amc_top #(.TICK_CYCLES(10)) i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .smp(smp), .meas_range(meas_range), .irq(irq));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // readies are sampled at the falling edge, where they hold what the next rising edge sees
   task wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
      logic pa, pw, a, w, b;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         a = pa && awready;
         w = pw && wready;
         @(posedge aclk);
         if (a) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (w) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      do begin
         @(negedge aclk);
         b = bvalid;
         r = bresp;
         @(posedge aclk);
      end while (!b);
      bready <= 1'b0;
      check({30'h0, r}, {30'h0, er});
   endtask

   task rd_reg(input logic [5:0] idx);
      logic a;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         a = arready;
         @(posedge aclk);
      end while (!a);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         a = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
      end while (!a);
      rready <= 1'b0;
   endtask

   task sample(input logic [15:0] x, input logic [15:0] y = 16'h0000,
      input logic [15:0] z = 16'h0000);
      @(posedge aclk);
      smp <= '{1'b1, x, y, z};
      @(posedge aclk);
      smp.valid <= 1'b0;
      cyc(3);
   endtask

   task stat_bit(input int b, input logic e);
      rd_reg(6'h31);
      check({31'h0, rd[b]}, {31'h0, e});
   endtask

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   initial begin
      repeat (30000) @(posedge aclk);
      mismatches++;
      results();
   end

   initial begin
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hF;
      smp = '0;
      meas_range = AMC_R2G;
      cyc(10);
      aresetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd_reg(ridx[i]);
         check(rd, {24'h000000, rval[i]});
      end
      // write-only top bit and reserved bits read back as zero
      wr(6'h23, 8'hFF);
      rd_reg(6'h23);
      check(rd, 32'h0000007F);
      wr(6'h24, 8'hFF);
      rd_reg(6'h24);
      check(rd, 32'h000000C7);
      wr(6'h3F, 8'h55, 2'b10);
      rd_reg(6'h3F);
      check({30'h0, rs}, 32'h00000002);
      // free-fall level 20 lsb, mode and hysteresis
      wr(6'h23, 8'h0A);
      wr(6'h24, 8'h00);
      sample(16'd10, 16'd10, 16'd10);
      stat_bit(4, 1'b1);
      wr(6'h24, 8'h04);
      sample(16'd10, 16'd10, 16'd10);
      stat_bit(4, 1'b0);
      wr(6'h24, 8'h01);
      sample(16'd0);
      stat_bit(4, 1'b1);
      sample(16'd40);
      stat_bit(4, 1'b1);
      sample(16'd60);
      stat_bit(4, 1'b0);
      // free-fall persistence of 5 ticks, then the interrupt path
      wr(6'h22, 8'h04);
      wr(6'h31, 8'h0F);
      sample(16'd0);
      cyc(25);
      stat_bit(0, 1'b0);
      cyc(30);
      stat_bit(0, 1'b1);
      check({31'h0, irq}, 32'h0);
      wr(6'h32, 8'h01);
      cyc(2);
      check({31'h0, irq}, 32'h1);
      wr(6'h31, 8'h01);
      cyc(2);
      check({31'h0, irq}, 32'h0);
      stat_bit(0, 1'b0);
      // shock level step per range, field 10
      wr(6'h24, 8'h00);
      wr(6'h26, 8'h0A);
      for (int r = 0; r < 4; r++) begin
         @(posedge aclk);
         meas_range <= amc_range_e'(r[1:0]);
         sample(16'((20 << r) + 5));
         stat_bit(5, 1'b1);
         sample(16'((20 << r) - 5));
         stat_bit(5, 1'b0);
         // free-fall level must not scale with the range
         stat_bit(4, r == 0);
      end
      // 4g: level 80 lsb, hysteresis 64 lsb
      meas_range <= AMC_R4G;
      wr(6'h26, 8'h14);
      wr(6'h24, 8'h40);
      sample(16'd100);
      stat_bit(5, 1'b1);
      sample(16'd30);
      stat_bit(5, 1'b1);
      sample(16'd10);
      stat_bit(5, 1'b0);
      wr(6'h25, 8'h02);
      wr(6'h31, 8'h0F);
      sample(16'd100);
      cyc(10);
      stat_bit(1, 1'b0);
      cyc(30);
      stat_bit(1, 1'b1);
      // slope runs: any-motion needs 3, slow-motion needs 2
      meas_range <= AMC_R2G;
      wr(6'h28, 8'h0A);
      wr(6'h27, 8'h06);
      wr(6'h30, 8'h00);
      sample(16'd0);
      sample(16'd0);
      wr(6'h31, 8'h0F);
      sample(16'd50);
      sample(16'd0);
      stat_bit(3, 1'b1);
      stat_bit(2, 1'b0);
      sample(16'd50);
      stat_bit(2, 1'b1);
      // at 16g both slope levels scale by 8, so a step of 50 is quiet
      meas_range <= AMC_R16G;
      sample(16'd0);
      sample(16'd0);
      wr(6'h31, 8'h0F);
      for (int i = 0; i < 2; i++) begin
         sample(16'd50);
         sample(16'd0);
      end
      stat_bit(2, 1'b0);
      stat_bit(3, 1'b0);
      // no-motion, duration code 1 decodes to 2 s, restarted by one real slope
      meas_range <= AMC_R2G;
      wr(6'h30, 8'h01);
      sample(16'd50);
      sample(16'd50);
      wr(6'h31, 8'h0F);
      cyc(9500);
      stat_bit(3, 1'b0);
      cyc(1000);
      stat_bit(3, 1'b1);
      results();
   end
endmodule
